// >>> hw/drm_pkg.sv
// shared constants and types for the row state and readout block
package drm_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MODE = 8'h04;
	localparam logic [7:0] OFF_BANK = 8'h08;
	localparam logic [7:0] OFF_ERR  = 8'h0C;
	localparam logic [3:0] CTRL_RL_RST = 4'h5;
	localparam int ERR_ACT_OPEN  = 0;
	localparam int ERR_IDLE_ACC  = 1;
	localparam int ERR_SR_BOTH   = 2;
	localparam int ERR_RSVD_LOC  = 3;

	// ---------------------------------------------------------------
	// command address fields
	// ---------------------------------------------------------------
	localparam int MR0_BL_LSB  = 0;
	localparam int MR2_ASR_BIT = 6;
	localparam int MR2_SRT_BIT = 7;
	localparam int MR3_MPR_BIT = 2;
	localparam int MR3_LOC_LSB = 0;
	localparam int A_HALF_BIT  = 2;
	localparam int A_AP_BIT    = 10;
	localparam int A_BC_BIT    = 12;
	localparam logic [7:0] CAL_PATTERN = 8'hAA;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 40;
	localparam int ROW_PRECHARGE_NS = 15;
	localparam int PRE_CYC_RAW = (ROW_PRECHARGE_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRE_CYCLES = (PRE_CYC_RAW < 1) ? 1 : PRE_CYC_RAW;

	// ---------------------------------------------------------------
	// enumerations
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_NOP = 3'b000, CMD_MRS = 3'b001, CMD_ACT = 3'b010, CMD_PRE = 3'b011,
		CMD_RD  = 3'b100, CMD_RDA = 3'b101, CMD_WR  = 3'b110, CMD_WRA = 3'b111
	} drm_cmd_t;
	typedef enum logic [1:0] {
		SR_NORMAL = 2'b00, SR_EXTENDED = 2'b01, SR_AUTO = 2'b10, SR_ILLEGAL = 2'b11
	} drm_sr_t;
	typedef enum logic [1:0] {
		BL_FIXED8 = 2'b00, BL_OTF = 2'b01, BL_FIXED4 = 2'b10
	} drm_bl_t;
	typedef enum logic [1:0] {
		BK_IDLE = 2'b00, BK_ACTIVE = 2'b01, BK_PRECHARGING = 2'b10
	} drm_bank_st_t;

endpackage : drm_pkg

// >>> hw/drm_bank.sv
// open/close state of one bank with its precharge timer
`timescale 1ns/100ps
module drm_bank
	import drm_pkg::*;
#(
	parameter int CNT_W      = 4,
	parameter int PRE_CYCLES_P = PRE_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        act,
	input  wire logic        pre,
	input  wire logic [15:0] row_in,
	output logic             is_open,
	output logic             is_prech,
	output logic [15:0]      open_row
);
	typedef struct packed {
		drm_bank_st_t st;
		logic [15:0]  row;
		logic [CNT_W-1:0] cnt;
	} drm_bank_s_t;

	drm_bank_s_t s_reg;
	drm_bank_s_t s_next;

	always_comb begin
		s_next = s_reg;
		case (s_reg.st)
			BK_ACTIVE: begin
				if (pre) begin
					s_next.st  = BK_PRECHARGING;
					s_next.cnt = CNT_W'(PRE_CYCLES_P - 1);
				end
			end
			BK_PRECHARGING: begin
				// RQ23 restart timer
				if (pre) begin
					s_next.cnt = CNT_W'(PRE_CYCLES_P - 1);
				end else if (s_reg.cnt == '0) begin
					s_next.st = BK_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 1'b1;
				end
			end
			default: begin
				// RQ17 open row
				if (act) begin
					s_next.st  = BK_ACTIVE;
					s_next.row = row_in;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{st: BK_IDLE, row: 16'h0000, cnt: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// RQ18 open until precharge
	assign is_open  = (s_reg.st == BK_ACTIVE);
	assign is_prech = (s_reg.st == BK_PRECHARGING);
	assign open_row = s_reg.row;

endmodule : drm_bank

// >>> hw/drm_mpr.sv
// readout burst serialiser driving the data lines
`timescale 1ns/100ps
module drm_mpr
	import drm_pkg::*;
#(
	parameter bit DQ_COPY = 1'b1
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       start,
	input  wire logic       half,
	input  wire logic       chop,
	input  wire logic [1:0] loc,
	output logic [7:0]      dq_out,
	output logic            dq_oe_n,
	output logic            beat_valid
);
	typedef struct packed {
		logic       busy;
		logic [2:0] beat;
		logic [2:0] last;
		logic [7:0] data;
		logic [7:0] dq;
		logic       oe_n;
	} drm_mpr_s_t;

	drm_mpr_s_t s_reg;
	drm_mpr_s_t s_next;
	logic       bit_now;
	logic [2:0] beat_now;

	always_comb begin
		s_next   = s_reg;
		bit_now  = 1'b0;
		beat_now = 3'h0;
		if (start) begin
			// RQ9 beat order
			beat_now    = (chop && half) ? 3'h4 : 3'h0;
			s_next.last = chop ? (beat_now + 3'h3) : 3'h7;
			// RQ15 pattern
			// reserved locations read as zero
			s_next.data = (loc == 2'b00) ? CAL_PATTERN : 8'h00;
			s_next.busy = 1'b1;
		end else begin
			beat_now = s_reg.beat + 3'h1;
			if (s_reg.beat == s_reg.last) begin
				s_next.busy = 1'b0;
			end
		end
		s_next.beat = beat_now;
		// RQ14 lsb first
		bit_now     = s_next.data[beat_now];
		s_next.oe_n = !s_next.busy;
		// RQ7 line 0 carries data
		s_next.dq   = s_next.busy ? {{7{DQ_COPY & bit_now}}, bit_now} : 8'h00;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{busy: 1'b0, beat: 3'h0, last: 3'h0, data: 8'h00, dq: 8'h00, oe_n: 1'b1};
		end else begin
			s_reg <= s_next;
		end
	end

	assign dq_out     = s_reg.dq;
	assign dq_oe_n    = s_reg.oe_n;
	assign beat_valid = s_reg.busy;

endmodule : drm_mpr

// >>> hw/drm_core.sv
// mode registers, bank row state, readout mode and apb access
// Notes on behaviour
// RQ1 - mode two bits six and seven zero: normal range self-refresh rate
// RQ2 - bit seven alone set: extended-range self-refresh rate on capable parts
// RQ3 - bit six alone set: automatic self-refresh following temperature
// RQ4 - controller never sets both self-refresh bits; flagged if it does
// RQ5 - mode three bit two clear: reads and writes use the array
// RQ6 - bit two set: reads return readout location from bits 1:0
// RQ7 - by-8 readout: line 0 carries data, lines 7:1 copy or zero
// RQ8 - controller keeps column bits 1:0 zero; bank bits ignored
// RQ9 - length eight fixed order; chop four halves chosen by bit 2
// RQ10 - address bit 12 chops on the fly when mode zero allows
// RQ11 - column bits 9:3, 10, 11, 13 and bank bits ignored
// RQ12 - readout reads use the ordinary read latency
// RQ13 - controller locks the delay loop before readout reads
// RQ14 - beat 0 is register lsb, beat 7 its msb
// RQ15 - location 00 gives alternating zero one calibration pattern
// RQ16 - controller avoids reserved locations; their data undefined
// RQ17 - activate opens the addressed row in the addressed bank
// RQ18 - row stays open until precharged; controller precharges first
// RQ19 - precharge closes one bank or all banks
// RQ20 - controller waits row precharge period before new activate
// RQ21 - controller may access other banks during auto precharge
// RQ22 - precharged bank idle; controller activates before access
// RQ23 - precharge accepted on idle banks; period restarts from latest
//
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module drm_core
	import drm_pkg::*;
#(
	parameter int NBANK      = 8,
	parameter bit EXT_TEMP   = 1'b1,
	parameter bit DQ_COPY    = 1'b1,
	parameter int MAX_RL     = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmd_valid,
	input  wire logic [2:0]  cmd_code,
	input  wire logic [2:0]  cmd_bank,
	input  wire logic [15:0] cmd_addr,
	input  wire logic        temp_hot,
	output logic [1:0]       sr_mode,
	output logic             sr_fast_rate,
	output logic             arr_rd,
	output logic             arr_wr,
	output logic [7:0]       dq_out,
	output logic             dq_oe_n,
	output logic             mpr_beat
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [3:0]        rl;
		drm_bl_t           bl;
		logic              auto_self_refresh_enable;
		logic              self_refresh_temp_range;
		logic              mpr_en;
		logic [1:0]        loc;
		logic [3:0]        err;
		logic [31:0]       rdata;
		logic [MAX_RL-1:0] pipe_v;
		logic [MAX_RL-1:0] pipe_mpr;
		logic [MAX_RL-1:0] pipe_half;
		logic [MAX_RL-1:0] pipe_chop;
		logic              arr_rd;
		logic              arr_wr;
		logic [1:0]        temp_sync;
		drm_sr_t           sr;
		logic              fast;
	} drm_core_s_t;

	drm_core_s_t s_reg;
	drm_core_s_t s_next;

	logic [NBANK-1:0] act_vec;
	logic [NBANK-1:0] pre_vec;
	logic [NBANK-1:0] bank_open;
	logic [NBANK-1:0] bank_prech;
	// open rows live inside the banks; no register reads them back
	logic [15:0]      bank_row [NBANK];

	logic        is_mrs;
	logic        is_act;
	logic        is_pre;
	logic        is_rd;
	logic        is_wr;
	logic        auto_pre;
	logic        rd_mpr;
	logic        rd_chop;
	logic [3:0]  rl_idx;
	logic        launch;
	logic        wr_acc;
	logic        addr_ok;
	logic [3:0]  err_set;

	// ---------------------------------------------------------------
	// per-bank row state
	// ---------------------------------------------------------------
	// one timer per bank, so an all-bank precharge and a single one
	// take the same path
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		drm_bank #(
			.CNT_W        (4),
			.PRE_CYCLES_P (PRE_CYCLES)
		) u_bank (
			.pclk     (pclk),
			.presetn  (presetn),
			.act      (act_vec[b]),
			.pre      (pre_vec[b]),
			.row_in   (cmd_addr),
			.is_open  (bank_open[b]),
			.is_prech (bank_prech[b]),
			.open_row (bank_row[b])
		);
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	always_comb begin
		is_mrs   = cmd_valid && (cmd_code == CMD_MRS);
		is_act   = cmd_valid && (cmd_code == CMD_ACT);
		is_pre   = cmd_valid && (cmd_code == CMD_PRE);
		is_rd    = cmd_valid && ((cmd_code == CMD_RD) || (cmd_code == CMD_RDA));
		is_wr    = cmd_valid && ((cmd_code == CMD_WR) || (cmd_code == CMD_WRA));
		auto_pre = cmd_valid && ((cmd_code == CMD_RDA) || (cmd_code == CMD_WRA));
		// RQ6 readout mode read
		// RQ11 bank and upper column ignored
		rd_mpr   = is_rd && s_reg.mpr_en;
		// RQ10 chop on the fly
		case (s_reg.bl)
			BL_OTF:    rd_chop = !cmd_addr[A_BC_BIT];
			BL_FIXED4: rd_chop = 1'b1;
			default:   rd_chop = 1'b0;
		endcase
		for (int b = 0; b < NBANK; b++) begin
			act_vec[b] = is_act && (cmd_bank == 3'(b));
			// RQ19 single or all banks
			pre_vec[b] = (is_pre && (cmd_addr[A_AP_BIT] || (cmd_bank == 3'(b))))
				|| (auto_pre && !rd_mpr && (cmd_bank == 3'(b)));
		end
	end

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	always_comb begin
		addr_ok = (paddr == OFF_CTRL) || (paddr == OFF_MODE) || (paddr == OFF_BANK) || (paddr == OFF_ERR);
		wr_acc  = psel && penable && pwrite && addr_ok;
		// apb answers in the first access cycle
		// every register is a flop or a plain decode, so no wait state is needed
		pready  = psel && penable;
		pslverr = psel && penable && !addr_ok;
	end

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next  = s_reg;
		err_set = 4'h0;
		// latency zero would index below the pipe, so it acts as one
		rl_idx  = (s_reg.rl == 4'h0) ? 4'h0 : (s_reg.rl - 4'h1);
		launch  = s_reg.pipe_v[rl_idx];

		// temperature pin synchroniser
		// the pin may move at any time; only the second flop is read
		s_next.temp_sync = {s_reg.temp_sync[0], temp_hot};

		// mode register writes, bank bits pick the register
		if (is_mrs) begin
			case (cmd_bank)
				3'h0: s_next.bl = drm_bl_t'(cmd_addr[MR0_BL_LSB +: 2]);
				3'h2: begin
					s_next.auto_self_refresh_enable = cmd_addr[MR2_ASR_BIT];
					s_next.self_refresh_temp_range = cmd_addr[MR2_SRT_BIT];
					// RQ4 illegal pair flagged
					err_set[ERR_SR_BOTH] = cmd_addr[MR2_ASR_BIT] && cmd_addr[MR2_SRT_BIT];
				end
				3'h3: begin
					// RQ5 normal or readout
					s_next.mpr_en = cmd_addr[MR3_MPR_BIT];
					s_next.loc    = cmd_addr[MR3_LOC_LSB +: 2];
				end
				default: begin
					// mode register one is not kept here; its writes fall away
				end
			endcase
		end

		// self-refresh option from the two mode bits
		// registered one cycle after the mode write, harmless since
		// self-refresh is entered far later
		case ({s_reg.self_refresh_temp_range, s_reg.auto_self_refresh_enable})
			// RQ1 normal rate
			2'b00: begin
				s_next.sr   = SR_NORMAL;
				s_next.fast = 1'b0;
			end
			// RQ2 extended rate
			2'b10: begin
				s_next.sr   = EXT_TEMP ? SR_EXTENDED : SR_NORMAL;
				s_next.fast = EXT_TEMP;
			end
			// RQ3 follows temperature
			2'b01: begin
				s_next.sr   = SR_AUTO;
				s_next.fast = s_reg.temp_sync[1];
			end
			// faster rate is the safe side for an illegal pair
			default: begin
				s_next.sr   = SR_ILLEGAL;
				s_next.fast = 1'b1;
			end
		endcase

		// RQ12 shared latency pipe
		// one shift register per attribute keeps array and readout reads
		// on the same latency; its depth caps the programmable value
		s_next.pipe_v    = {s_reg.pipe_v[MAX_RL-2:0], is_rd};
		s_next.pipe_mpr  = {s_reg.pipe_mpr[MAX_RL-2:0], rd_mpr};
		// RQ9 half only for chop
		s_next.pipe_half = {s_reg.pipe_half[MAX_RL-2:0], rd_chop && cmd_addr[A_HALF_BIT]};
		s_next.pipe_chop = {s_reg.pipe_chop[MAX_RL-2:0], rd_chop};
		s_next.arr_rd    = launch && !s_reg.pipe_mpr[rl_idx];
		// RQ5 array writes only
		// readout mode shields the array from writes
		s_next.arr_wr    = is_wr && !s_reg.mpr_en;

		// RQ18 activate onto busy bank
		err_set[ERR_ACT_OPEN] = is_act && (bank_open[cmd_bank] || bank_prech[cmd_bank]);
		// RQ22 access to idle bank
		err_set[ERR_IDLE_ACC] = (is_wr || (is_rd && !rd_mpr)) && !bank_open[cmd_bank];
		// reserved locations read as zero; the attempt is recorded
		err_set[ERR_RSVD_LOC] = rd_mpr && (s_reg.loc != 2'b00);

		// apb writes
		if (wr_acc && (paddr == OFF_CTRL)) begin
			s_next.rl = pwdata[3:0];
		end
		// set wins over write-one-to-clear
		if (wr_acc && (paddr == OFF_ERR)) begin
			s_next.err = (s_reg.err & ~pwdata[3:0]) | err_set;
		end else begin
			s_next.err = s_reg.err | err_set;
		end

		// read data captured in the setup cycle
		// so prdata is a flop output that stands through the access phase
		if (psel && !penable) begin
			case (paddr)
				OFF_CTRL: s_next.rdata = {28'h000_0000, s_reg.rl};
				OFF_MODE: s_next.rdata = {20'h0_0000, s_reg.sr, s_reg.loc, s_reg.mpr_en,
					s_reg.self_refresh_temp_range, s_reg.auto_self_refresh_enable, 1'b0, s_reg.bl, s_reg.fast, 1'b0};
				OFF_BANK: s_next.rdata = {16'h0000, 8'(bank_prech), 8'(bank_open)};
				OFF_ERR:  s_next.rdata = {28'h000_0000, s_reg.err};
				default:  s_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '{rl: CTRL_RL_RST, bl: BL_FIXED8, sr: SR_NORMAL, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// readout serialiser
	// ---------------------------------------------------------------
	drm_mpr #(
		.DQ_COPY (DQ_COPY)
	) u_mpr (
		.pclk       (pclk),
		.presetn    (presetn),
		.start      (launch && s_reg.pipe_mpr[rl_idx]),
		.half       (s_reg.pipe_half[rl_idx]),
		.chop       (s_reg.pipe_chop[rl_idx]),
		.loc        (s_reg.loc),
		.dq_out     (dq_out),
		.dq_oe_n    (dq_oe_n),
		.beat_valid (mpr_beat)
	);

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	// all data outputs come straight from flops
	assign prdata       = s_reg.rdata;
	assign sr_mode      = s_reg.sr;
	assign sr_fast_rate = s_reg.fast;
	assign arr_rd       = s_reg.arr_rd;
	assign arr_wr       = s_reg.arr_wr;

endmodule : drm_core

// >>> verification/drm_core_monitor.sv
// assertions on the readout, write and self-refresh ports of the core
`timescale 1ns/100ps
module drm_core_monitor
	import drm_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       cmd_valid,
	input wire logic [2:0] cmd_code,
	input wire logic [1:0] sr_mode,
	input wire logic       sr_fast_rate,
	input wire logic       arr_wr,
	input wire logic [7:0] dq_out,
	input wire logic       dq_oe_n,
	input wire logic       mpr_beat
);
	logic [3:0] run_reg;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ---------------------------------------------------------------
	// beat run counter
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_reg <= 4'h0;
		else
			run_reg <= mpr_beat ? run_reg + 4'h1 : 4'h0;
	end
	chk_sr_normal: assert property (sr_mode == SR_NORMAL |-> !sr_fast_rate)
		else $error("normal range with fast rate");
	chk_sr_extended: assert property (sr_mode == SR_EXTENDED |-> sr_fast_rate)
		else $error("extended range without fast rate");
	chk_beat_oe: assert property (mpr_beat |-> !dq_oe_n)
		else $error("beat without output drive");
	chk_dq_copy: assert property (mpr_beat |-> dq_out == {8{dq_out[0]}})
		else $error("upper lines differ from line zero");
	chk_beat_len: assert property ($fell(mpr_beat) |-> run_reg == 4'h4 || run_reg == 4'h8)
		else $error("burst neither four nor eight beats");
	chk_first_beat: assert property ($rose(mpr_beat) |-> !dq_out[0])
		else $error("first beat not zero");
	chk_rd_latency: assert property ($rose(mpr_beat) |-> $past(cmd_valid, 6) && $past(cmd_code[2:1], 6) == 2'b10)
		else $error("readout not six cycles after read");
	chk_wr_pulse: assert property ($rose(arr_wr) |-> $past(cmd_valid) && $past(cmd_code[2:1]) == 2'b11 ##1 !arr_wr)
		else $error("array write pulse wrong");
endmodule : drm_core_monitor
bind drm_core drm_core_monitor u_mon (.pclk, .presetn, .cmd_valid, .cmd_code, .sr_mode, .sr_fast_rate,
	.arr_wr, .dq_out, .dq_oe_n, .mpr_beat);

// >>> verification/drm_ctl_model.sv
// controller model turning bench requests into device commands
`timescale 1ns/100ps
module drm_ctl_model
	import drm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        req,
	input  wire logic [2:0]  req_code,
	input  wire logic [2:0]  req_bank,
	input  wire logic [15:0] req_addr,
	output logic             cmd_valid,
	output logic [2:0]       cmd_code,
	output logic [2:0]       cmd_bank,
	output logic [15:0]      cmd_addr
);
	logic [3:0] wait_reg;
	logic       blk;
	assign blk = (req_code == CMD_ACT) && (wait_reg != 4'h0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_valid <= 1'b0;
			cmd_code <= CMD_NOP;
			cmd_bank <= 3'h0;
			cmd_addr <= 16'h0000;
			wait_reg <= 4'h0;
		end else begin
			cmd_valid <= req && !blk;
			// released lines never keep the last value
			cmd_code <= ~cmd_code;
			cmd_bank <= ~cmd_bank;
			cmd_addr <= ~cmd_addr;
			if (wait_reg != 4'h0)
				wait_reg <= wait_reg - 4'h1;
			if (req && !blk) begin
				cmd_code <= req_code;
				cmd_bank <= req_bank;
				// read column bits low, loop locked
				cmd_addr <= req_code[2:1] == 2'b10 ? {req_addr[15:2], 2'b00} : req_addr;
				if (req_code == CMD_PRE)
					wait_reg <= PRE_CYCLES[3:0];
			end
		end
	end
endmodule : drm_ctl_model

// >>> verification/drm_core_tb.sv
// self-checking bench for the row state and readout core
`timescale 1ns/100ps
module drm_core_tb;
	import drm_pkg::*;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        req = 1'b0;
	logic [2:0]  req_code = 3'h0;
	logic [2:0]  req_bank = 3'h0;
	logic [15:0] req_addr = 16'h0000;
	logic        cmd_valid;
	logic [2:0]  cmd_code;
	logic [2:0]  cmd_bank;
	logic [15:0] cmd_addr;
	logic        temp_hot = 1'b0;
	logic [1:0]  sr_mode;
	logic        sr_fast_rate;
	logic        arr_rd;
	logic        arr_wr;
	logic [7:0]  dq_out;
	logic        dq_oe_n;
	logic        mpr_beat;
	logic [31:0] lfsr = 32'hfc25_4904;
	logic [31:0] rd;
	logic        e;
	int          n_mismatch = 0;
	int          compares = 0;
	always #20 pclk = ~pclk;
	drm_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cmd_valid, .cmd_code, .cmd_bank, .cmd_addr, .temp_hot, .sr_mode, .sr_fast_rate, .arr_rd,
		.arr_wr, .dq_out, .dq_oe_n, .mpr_beat);
	drm_ctl_model u_ctl (.pclk, .presetn, .req, .req_code, .req_bank, .req_addr, .cmd_valid, .cmd_code,
		.cmd_bank, .cmd_addr);
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : nxt
	function automatic logic exp_bit(input logic [1:0] loc, input int idx);
		return (loc == 2'b00) ? idx[0] : 1'b0;
	endfunction : exp_bit
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// returns at the edge where the core takes the command
	task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
		int n;
		@(posedge pclk);
		req <= 1'b1;
		req_code <= c;
		req_bank <= b;
		req_addr <= a;
		n = 0;
		// the model grants at the first edge where its precharge hold is off
		do begin
			@(posedge pclk);
			n++;
		end while (u_ctl.blk && n < 20);
		req <= 1'b0;
		@(posedge pclk);
	endtask : cmd
	task automatic burst(input logic [15:0] a, input logic [1:0] loc, input int len, input int first);
		int k;
		lfsr = nxt(lfsr);
		cmd(CMD_RD, lfsr[2:0], a);
		k = 0;
		do begin
			@(posedge pclk);
			#1;
			k++;
		end while (mpr_beat !== 1'b1 && k < 20);
		chk(k == CTRL_RL_RST, "readout latency");
		for (int i = 0; i < len; i++) begin
			chk(dq_out === {8{exp_bit(loc, first + i)}} && dq_oe_n === 1'b0, "beat data");
			@(posedge pclk);
			#1;
		end
		chk(mpr_beat === 1'b0, "burst length");
	endtask : burst
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// ---------------------------------------------------------------
	// tests
	// ---------------------------------------------------------------
	initial begin
		int k;
		logic [2:0] b;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(rd[3:0] === CTRL_RL_RST, "latency reset value");
		apb(1'b1, OFF_CTRL, 32'h0000_0009);
		apb(1'b0, OFF_CTRL, 32'h0000_0000);
		chk(rd[3:0] === 4'h9, "latency readback");
		apb(1'b1, OFF_CTRL, {28'h000_0000, CTRL_RL_RST});
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(e === 1'b1 && rd === 32'h0000_0000, "unmapped address");
		$display("registers done");
		// mode two bit pairs at both temperatures
		for (int m = 0; m < 8; m++) begin
			lfsr = nxt(lfsr);
			temp_hot <= m[0];
			cmd(CMD_MRS, 3'h2, (lfsr[15:0] & 16'hff3f) | {8'h00, m[2], m[1], 6'h00});
			repeat (4) @(posedge pclk);
			chk(sr_mode === {m[1], m[2]}, "self-refresh mode");
			chk(sr_fast_rate === ((m[2:1] == 2'b01) ? m[0] : (m[2:1] != 2'b00)), "refresh rate");
		end
		apb(1'b0, OFF_ERR, 32'h0000_0000);
		chk(rd[2] === 1'b1, "both refresh bits flagged");
		apb(1'b1, OFF_ERR, 32'h0000_000f);
		$display("self-refresh done");
		b = lfsr[2:0];
		cmd(CMD_ACT, b, lfsr[31:16]);
		cmd(CMD_ACT, b, ~lfsr[31:16]);
		cmd(CMD_PRE, b ^ 3'h1, 16'h0000);
		apb(1'b0, OFF_BANK, 32'h0000_0000);
		chk(rd[7:0] === 8'h01 << b, "row open in bank");
		apb(1'b0, OFF_ERR, 32'h0000_0000);
		chk(rd[0] === 1'b1, "activate of open bank flagged");
		cmd(CMD_WR, b, 16'h0000);
		#1;
		chk(arr_wr === 1'b1, "array write");
		cmd(CMD_PRE, b, 16'h0000);
		cmd(CMD_PRE, b, 16'h0000);
		cmd(CMD_RD, b, 16'h0000);
		apb(1'b0, OFF_BANK, 32'h0000_0000);
		chk(rd[15:0] === 16'h0000, "bank closed");
		apb(1'b0, OFF_ERR, 32'h0000_0000);
		chk(rd[1] === 1'b1, "read of idle bank flagged");
		apb(1'b1, OFF_ERR, 32'h0000_000f);
		cmd(CMD_ACT, b, 16'h0000);
		cmd(CMD_ACT, b ^ 3'h4, 16'h0000);
		cmd(CMD_WRA, b ^ 3'h4, 16'h0000);
		cmd(CMD_RD, b, 16'h0000);
		k = 0;
		do begin
			@(posedge pclk);
			#1;
			k++;
		end while (arr_rd !== 1'b1 && k < 12);
		chk(k < 12 && mpr_beat === 1'b0, "array read");
		apb(1'b0, OFF_ERR, 32'h0000_0000);
		chk(rd[1:0] === 2'b00, "legal row traffic flagged");
		cmd(CMD_PRE, b, 16'h0400);
		apb(1'b0, OFF_BANK, 32'h0000_0000);
		chk(rd[15:0] === 16'h0000, "all banks closed");
		$display("bank rows done");
		cmd(CMD_MRS, 3'h3, 16'h0004);
		burst(lfsr[15:0] & 16'h2ff8, 2'b00, 8, 0);
		cmd(CMD_MRS, 3'h0, 16'h0001);
		for (int h = 0; h < 2; h++) begin
			lfsr = nxt(lfsr);
			burst((lfsr[15:0] & 16'h2ff8) | (16'h0004 * h), 2'b00, 4, 4 * h);
		end
		burst(16'h1000, 2'b00, 8, 0);
		cmd(CMD_MRS, 3'h0, 16'h0002);
		burst(16'h0004, 2'b00, 4, 4);
		cmd(CMD_MRS, 3'h0, 16'h0000);
		cmd(CMD_MRS, 3'h3, 16'h0005);
		burst(16'h0000, 2'b01, 8, 0);
		apb(1'b0, OFF_ERR, 32'h0000_0000);
		chk(rd[3] === 1'b1, "reserved location flagged");
		$display("readout done");
		end_sim();
	end
	// whole run needs well under two thousand cycles
	initial begin
		repeat (6000) @(posedge pclk);
		n_mismatch++;
		end_sim();
	end
endmodule : drm_core_tb
